// ==== common/bspc_pkg.sv ====
// Operation
// - Port 61h bit 1 drives the speaker directly when toggled by software.
// - Timer channel 2 output can be routed to the speaker.
// - Port 61h bit 0 gates the timer prescale clock.
// - Enter standby after selected idle minutes (1 to 239) with no key.
// - Any key in standby returns to normal; program state untouched.
// - Idle timeout setting accepted in one-minute steps, 1 to 239 minutes.
// - Green indicator lit for as long as standby lasts.
// - First low-battery warning: red indicator steady and two beeps.
// - Second low-battery warning: red indicator flashing and five beeps.
// - Red low-battery indication continues during standby.
// - Running on past the warning shuts the system down.
// - 5 V rail enable active high; 12 V enable active low.
package bspc_pkg;

  // ----------------------------------------------------------------------
  // Port map and fields
  // ----------------------------------------------------------------------
  localparam logic [7:0] SPK_PORT_ADDR = 8'h61;
  localparam logic [7:0] SPK_PORT_RESET = 8'h00;
  localparam int BIT_PRESCALE_GATE = 0;
  localparam int BIT_SPK_DIRECT = 1;
  localparam int BIT_TIMER_ROUTE = 2;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ = 100_000_000;
  localparam int SECONDS_PER_MIN = 60;
  localparam int IDLE_MIN_LO = 1;
  localparam int IDLE_MIN_HI = 239;
  localparam int BEEP_MS = 100;
  localparam int BEEP_CYCLES = CLK_HZ / 1000 * BEEP_MS;
  localparam int FLASH_MS = 500;
  localparam int FLASH_CYCLES = CLK_HZ / 1000 * FLASH_MS;
  localparam int TONE_HZ = 2000;
  localparam int TONE_HALF_CYCLES = CLK_HZ / TONE_HZ / 2;
  localparam logic [2:0] BEEPS_FIRST = 3'h2;
  localparam logic [2:0] BEEPS_SECOND = 3'h5;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    BSPC_RUN = 2'b01,
    BSPC_STANDBY = 2'b10
  } bspc_pwr_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bspc_io_t;

  typedef struct packed {
    logic rail5_en;
    logic rail12_en_b;
  } bspc_rails_t;

endpackage : bspc_pkg

// ==== hw/bspc_beeper.sv ====
`timescale 1ns/1ns
`default_nettype none
module bspc_beeper #(
  parameter int BEEP_LEN = bspc_pkg::BEEP_CYCLES,
  parameter int HALF_TONE = bspc_pkg::TONE_HALF_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic [2:0] count,
  output logic busy,
  output logic tone
);
  // ----------------------------------------------------------------------
  // Beep burst: count beeps, each BEEP_LEN on then BEEP_LEN off
  // ----------------------------------------------------------------------
  logic [2:0] left;
  logic phase_on;
  logic [31:0] len_cnt;
  logic [31:0] tone_cnt;
  logic tone_sq;
  wire len_done = (len_cnt == 32'(BEEP_LEN - 1));
  wire tone_wrap = (tone_cnt == 32'(HALF_TONE - 1));

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      left <= 3'h0;
      phase_on <= 1'b0;
      len_cnt <= 32'h0;
    end else if (start) begin
      left <= count;
      phase_on <= 1'b1;
      len_cnt <= 32'h0;
    end else if (left != 3'h0) begin
      len_cnt <= len_done ? 32'h0 : len_cnt + 32'h1;
      if (len_done) begin
        phase_on <= !phase_on;
        if (!phase_on) left <= left - 3'h1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tone_cnt <= 32'h0;
      tone_sq <= 1'b0;
    end else begin
      tone_cnt <= tone_wrap ? 32'h0 : tone_cnt + 32'h1;
      if (tone_wrap) tone_sq <= !tone_sq;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) tone <= 1'b0;
    else tone <= (left != 3'h0) && phase_on && tone_sq;
  end

  assign busy = (left != 3'h0);
endmodule : bspc_beeper
`default_nettype wire

// ==== hw/bspc_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module bspc_top #(
  // A minute of system clock does not fit a 32-bit int
  parameter longint CYC_PER_MIN = longint'(bspc_pkg::CLK_HZ) *
    bspc_pkg::SECONDS_PER_MIN,
  parameter int BEEP_LEN = bspc_pkg::BEEP_CYCLES,
  parameter int FLASH_LEN = bspc_pkg::FLASH_CYCLES,
  parameter int HALF_TONE = bspc_pkg::TONE_HALF_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire bspc_pkg::bspc_io_t io,
  output logic [7:0] io_rdata,
  input wire logic timer_ch2_out,
  input wire logic timer_prescale_clock,
  output logic timer_prescale_gated,
  output logic speaker,
  input wire logic key_strobe,
  input wire logic [7:0] idle_minutes,
  input wire logic setup_load,
  input wire logic batt_low1,
  input wire logic batt_low2,
  input wire logic batt_dead,
  output logic standby,
  output logic led_green,
  output logic led_red,
  output logic shutdown,
  output bspc_pkg::bspc_rails_t rails
);
  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [6:0] sync1;
  logic [6:0] sync2;
  wire [6:0] pins = {timer_ch2_out, timer_prescale_clock, key_strobe,
                     batt_low1, batt_low2, batt_dead, setup_load};

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sync1 <= 7'h00;
      sync2 <= 7'h00;
    end else begin
      sync1 <= pins;
      sync2 <= sync1;
    end
  end

  wire ch2_s = sync2[6];
  wire pclk_s = sync2[5];
  wire key_s = sync2[4];
  wire low1_s = sync2[3];
  wire low2_s = sync2[2];
  wire dead_s = sync2[1];
  wire load_s = sync2[0];

  logic [7:0] idle_s1;
  logic [7:0] idle_s2;

  // Setting bits pass the same two stages as the load strobe
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      idle_s1 <= 8'h00;
      idle_s2 <= 8'h00;
    end else begin
      idle_s1 <= idle_minutes;
      idle_s2 <= idle_s1;
    end
  end

  logic key_d;
  logic low1_d;
  logic low2_d;
  logic load_d;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      key_d <= 1'b0;
      low1_d <= 1'b0;
      low2_d <= 1'b0;
      load_d <= 1'b0;
    end else begin
      key_d <= key_s;
      low1_d <= low1_s;
      low2_d <= low2_s;
      load_d <= load_s;
    end
  end
  wire key_evt = key_s && !key_d;
  wire low1_evt = low1_s && !low1_d;
  wire low2_evt = low2_s && !low2_d;
  wire load_evt = load_s && !load_d;

  // ----------------------------------------------------------------------
  // Port 61h
  // ----------------------------------------------------------------------
  logic [7:0] port61;
  wire port_hit = (io.addr == bspc_pkg::SPK_PORT_ADDR);
  wire port_wr = io.wr && port_hit;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) port61 <= bspc_pkg::SPK_PORT_RESET;
    else if (port_wr) port61 <= io.wdata;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) io_rdata <= 8'h00;
    else if (io.rd && port_hit) io_rdata <= port61;
    else io_rdata <= 8'h00;
  end

  wire gate_bit = port61[bspc_pkg::BIT_PRESCALE_GATE];
  wire direct_bit = port61[bspc_pkg::BIT_SPK_DIRECT];
  wire route_bit = port61[bspc_pkg::BIT_TIMER_ROUTE];

  // ----------------------------------------------------------------------
  // Idle timeout setting
  // ----------------------------------------------------------------------
  logic [7:0] idle_set;
  wire set_ok = (idle_s2 >= 8'(bspc_pkg::IDLE_MIN_LO)) &&
                (idle_s2 <= 8'(bspc_pkg::IDLE_MIN_HI));

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) idle_set <= 8'(bspc_pkg::IDLE_MIN_HI);
    else if (load_evt && set_ok) idle_set <= idle_s2;
  end

  // ----------------------------------------------------------------------
  // Idle counter and standby
  // ----------------------------------------------------------------------
  bspc_pkg::bspc_pwr_t pwr;
  bspc_pkg::bspc_pwr_t next_pwr;
  logic [32:0] sub_cnt;
  logic [7:0] min_cnt;
  wire min_tick = (sub_cnt == 33'(CYC_PER_MIN - 1));
  wire timeout = (min_cnt >= idle_set);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sub_cnt <= 33'h0;
      min_cnt <= 8'h00;
    end else if (key_evt || pwr == bspc_pkg::BSPC_STANDBY) begin
      sub_cnt <= 33'h0;
      min_cnt <= 8'h00;
    end else begin
      sub_cnt <= min_tick ? 33'h0 : sub_cnt + 33'h1;
      if (min_tick && !timeout) min_cnt <= min_cnt + 8'h01;
    end
  end

  always_comb begin
    next_pwr = pwr;
    unique case (pwr)
      bspc_pkg::BSPC_RUN: begin
        if (timeout && !key_evt) next_pwr = bspc_pkg::BSPC_STANDBY;
      end
      bspc_pkg::BSPC_STANDBY: begin
        if (key_evt) next_pwr = bspc_pkg::BSPC_RUN;
      end
      default: next_pwr = bspc_pkg::BSPC_RUN;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) pwr <= bspc_pkg::BSPC_RUN;
    else pwr <= next_pwr;
  end

  assign standby = (pwr == bspc_pkg::BSPC_STANDBY);
  assign led_green = standby;

  // ----------------------------------------------------------------------
  // Low-battery warnings
  // ----------------------------------------------------------------------
  logic warn1;
  logic warn2;
  logic shut;
  logic [31:0] flash_cnt;
  logic flash;
  wire flash_wrap = (flash_cnt == 32'(FLASH_LEN - 1));

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      warn1 <= 1'b0;
      warn2 <= 1'b0;
      shut <= 1'b0;
    end else begin
      if (low1_evt) warn1 <= 1'b1;
      if (low2_evt) warn2 <= 1'b1;
      if (dead_s && (warn1 || warn2)) shut <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      flash_cnt <= 32'h0;
      flash <= 1'b0;
    end else begin
      flash_cnt <= flash_wrap ? 32'h0 : flash_cnt + 32'h1;
      if (flash_wrap) flash <= !flash;
    end
  end

  // Red shown in both run and standby
  assign led_red = warn2 ? flash : warn1;
  assign shutdown = shut;

  wire beep_start = low1_evt || low2_evt;
  wire [2:0] beep_num = low2_evt ? bspc_pkg::BEEPS_SECOND
                                 : bspc_pkg::BEEPS_FIRST;
  logic beep_busy;
  logic beep_tone;

  bspc_beeper #(
    .BEEP_LEN(BEEP_LEN),
    .HALF_TONE(HALF_TONE)
  ) u_beeper (
    .mclk(mclk),
    .rst_b(rst_b),
    .start(beep_start),
    .count(beep_num),
    .busy(beep_busy),
    .tone(beep_tone)
  );

  // ----------------------------------------------------------------------
  // Speaker, prescale gate, rails
  // ----------------------------------------------------------------------
  wire spk_next = direct_bit ^ (route_bit && ch2_s) ^ beep_tone;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      speaker <= 1'b0;
      timer_prescale_gated <= 1'b0;
    end else begin
      speaker <= spk_next;
      timer_prescale_gated <= pclk_s && gate_bit;
    end
  end

  assign rails = '{rail5_en: !shut, rail12_en_b: shut};

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_direct;
    @(posedge mclk) disable iff (!rst_b)
      (!route_bit && !beep_busy && !$past(beep_busy)) |=>
        (speaker == $past(direct_bit));
  endproperty
  a_direct: assert property (p_direct) else $error("speaker not direct");

  property p_route;
    @(posedge mclk) disable iff (!rst_b)
      (route_bit && !direct_bit && !beep_busy && !$past(beep_busy)) |=>
        (speaker == $past(ch2_s));
  endproperty
  a_route: assert property (p_route) else $error("ch2 not routed");

  property p_gate;
    @(posedge mclk) disable iff (!rst_b)
      !gate_bit |=> !timer_prescale_gated;
  endproperty
  a_gate: assert property (p_gate) else $error("prescale not gated");

  property p_enter;
    @(posedge mclk) disable iff (!rst_b)
      (pwr == bspc_pkg::BSPC_RUN && timeout && !key_evt) |=> standby;
  endproperty
  a_enter: assert property (p_enter) else $error("standby missed");

  property p_wake;
    @(posedge mclk) disable iff (!rst_b)
      (standby && key_evt) |=> !standby;
  endproperty
  a_wake: assert property (p_wake) else $error("key did not wake");

  property p_green;
    @(posedge mclk) disable iff (!rst_b)
      led_green == standby;
  endproperty
  a_green: assert property (p_green) else $error("green led wrong");

  property p_red1;
    @(posedge mclk) disable iff (!rst_b)
      (low1_evt && !warn2 && !low2_evt) |=> led_red ##1 led_red;
  endproperty
  a_red1: assert property (p_red1) else $error("red led not steady");

  property p_restart;
    @(posedge mclk) disable iff (!rst_b)
      key_evt |=> (min_cnt == 8'h00 && sub_cnt == 33'h0);
  endproperty
  a_restart: assert property (p_restart) else $error("idle count kept");

  property p_rails;
    @(posedge mclk) disable iff (!rst_b)
      (dead_s && (warn1 || warn2)) |=>
        (!rails.rail5_en && rails.rail12_en_b);
  endproperty
  a_rails: assert property (p_rails) else $error("rails not off");

  property p_reject;
    @(posedge mclk) disable iff (!rst_b)
      (load_evt && !set_ok) |=> (idle_set == $past(idle_set));
  endproperty
  a_reject: assert property (p_reject) else $error("bad setting taken");

  property p_beep;
    @(posedge mclk) disable iff (!rst_b)
      beep_start |=> beep_busy;
  endproperty
  a_beep: assert property (p_beep) else $error("beeps not started");
endmodule : bspc_top
`default_nettype wire

// ==== verif/bspc_far_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Keyboard and speaker listener
// ----------------------------------------
module bspc_far_model (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic press,
  input wire logic speaker,
  output logic key_strobe,
  output int bursts
);
  logic [2:0] hold;
  logic last;
  int gap;
  assign key_strobe = hold != 3'h0;
  // A burst is speaker activity after a long quiet gap
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      hold <= 3'h0;
      last <= 1'b0;
      gap <= 99;
      bursts <= 0;
    end else begin
      if (press) hold <= 3'h3;
      else if (hold != 3'h0) hold <= hold - 3'h1;
      last <= speaker;
      if (speaker != last) begin
        gap <= 0;
        if (gap > 6) bursts <= bursts + 1;
      end else if (gap < 99) gap <= gap + 1;
    end
  end
endmodule : bspc_far_model
`default_nettype wire

// ==== verif/beeper_standby_power_control_tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module beeper_standby_power_control_tb_top;
  localparam int MIN = 20;
  logic mclk, rst_b, ch2, pre, key, ld, b1, b2, bd, press;
  logic gated, spk, stby, grn, red, sdn;
  logic [7:0] rdata, idle_min;
  bspc_pkg::bspc_io_t io;
  bspc_pkg::bspc_rails_t rails;
  int n_errors, checks, seed, bursts, m_port, base, n, r;
  // ----------------------------------------
  // Design and far side
  // ----------------------------------------
  bspc_top #(.CYC_PER_MIN(MIN), .BEEP_LEN(8), .FLASH_LEN(4),
    .HALF_TONE(2)) u_dut (.mclk(mclk), .rst_b(rst_b), .io(io),
    .io_rdata(rdata), .timer_ch2_out(ch2), .timer_prescale_clock(pre),
    .timer_prescale_gated(gated), .speaker(spk), .key_strobe(key),
    .idle_minutes(idle_min), .setup_load(ld), .batt_low1(b1),
    .batt_low2(b2), .batt_dead(bd), .standby(stby), .led_green(grn),
    .led_red(red), .shutdown(sdn), .rails(rails));
  bspc_far_model u_far (.mclk(mclk), .rst_b(rst_b), .press(press),
    .speaker(spk), .key_strobe(key), .bursts(bursts));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk1(input string what, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s exp %b got %b", what, e, g);
    end
  endtask : chk1
  task automatic chk8(input string what, input logic [7:0] e,
    input logic [7:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", what, e, g);
    end
  endtask : chk8
  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
  endtask : cyc
  task automatic iow(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    io <= '{1'b1, 1'b0, a, d};
    @(posedge mclk);
    io <= '0;
    if (a == 8'h61) m_port = d;
  endtask : iow
  task automatic ior(input logic [7:0] a);
    @(posedge mclk);
    io <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge mclk);
    io <= '0;
    #1;
    chk8("io_rdata", a == 8'h61 ? m_port[7:0] : 8'h00, rdata);
  endtask : ior
  task automatic key_tap();
    @(posedge mclk);
    press <= 1'b1;
    @(posedge mclk);
    press <= 1'b0;
  endtask : key_tap
  task automatic set_idle(input logic [7:0] v);
    @(posedge mclk);
    idle_min <= v;
    ld <= 1'b1;
    cyc(4);
    ld <= 1'b0;
    cyc(4);
  endtask : set_idle
  task automatic idle_run(input int mins);
    key_tap();
    cyc(5);
    n = 6;
    while (stby !== 1'b1 && n < 200) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk1("idle span", 1'b1, n >= mins * MIN && n <= mins * MIN + 10);
  endtask : idle_run
  task automatic flash();
    n = 0;
    repeat (16) begin
      @(posedge mclk);
      #1;
      n += int'(red === 1'b1);
    end
    chk1("led_red flash", 1'b1, n > 0 && n < 16);
  endtask : flash
  task automatic wrap_up();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up
  // ----------------------------------------
  // Clock, watchdog, tests
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    #40000;
    n_errors++;
    wrap_up();
  end
  initial begin
    seed = 32'hf661;
    {rst_b, ch2, pre, ld, b1, b2, bd, press} = '0;
    io = '0;
    idle_min = 8'h00;
    m_port = 0;
    cyc(10);
    rst_b <= 1'b1;
    cyc(1);
    #1;
    chk1("rail5_en", 1'b1, rails.rail5_en);
    chk1("rail12_en_b", 1'b0, rails.rail12_en_b);
    ior(8'h61);
    ior(8'h62);
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      iow(8'h61, r[7:0]);
      iow(8'h60, r[15:8]);
      ch2 <= r[16];
      pre <= r[17];
      cyc(5);
      #1;
      ior(8'h61);
      chk1("speaker", m_port[1] ^ (m_port[2] & ch2), spk);
      chk1("gated", pre & m_port[0], gated);
    end
    iow(8'h61, 8'h00);
    ch2 <= 1'b0;
    cyc(5);
    base = bursts;
    b1 <= 1'b1;
    cyc(70);
    chk8("beeps 1", 8'h02, 8'(bursts - base));
    chk1("led_red", 1'b1, red);
    base = bursts;
    b2 <= 1'b1;
    cyc(110);
    chk8("beeps 2", 8'h05, 8'(bursts - base));
    flash();
    set_idle(8'h01);
    key_tap();
    cyc(12);
    idle_run(1);
    chk1("led_green", 1'b1, grn);
    flash();
    key_tap();
    cyc(6);
    #1;
    chk1("standby", 1'b0, stby);
    chk1("led_green", 1'b0, grn);
    ior(8'h61);
    set_idle(8'hf0);
    idle_run(1);
    set_idle(8'h02);
    idle_run(2);
    chk1("shutdown", 1'b0, sdn);
    @(posedge mclk);
    bd <= 1'b1;
    cyc(5);
    #1;
    chk1("shutdown", 1'b1, sdn);
    chk1("rail5_en", 1'b0, rails.rail5_en);
    chk1("rail12_en_b", 1'b1, rails.rail12_en_b);
    wrap_up();
  end
endmodule : beeper_standby_power_control_tb_top
`default_nettype wire
